// ---- bench/fifo_status_flag_logic_test.sv ----
// self-checking bench for the fifo flag core, both modes
// assumes link_model drives the pins; queues predict every word
`timescale 1ns/1ns
module fifo_status_flag_logic_test import fifo_flag_pkg::*; ;
    localparam int D = 4;
    // offset register is only as wide as the fill pointer
    localparam int PW = $clog2(2 * D + 2);
    logic clock, sys_rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, r;
    logic wclk_pin, wen_n, rclk_pin, ren_n, master_reset_n, partial_reset_n;
    logic full_flag_n, empty_indicator_n, almost_full_flag_n;
    logic rd_valid, rd_ready;
    logic [DATA_W-1:0] wr_data, q_data, rd_data, last;
    logic [DATA_W-1:0] mq[$], sq[$];
    int err_count, check_count, cap, m;
    bit fw, full_exp, paf_exp;
    fifo_flag_core #(.DEPTH(D)) fifo_flag_core_i (
        .clock, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
        .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wclk_pin, .wen_n,
        .wr_data, .rclk_pin, .ren_n, .master_reset_n, .partial_reset_n,
        .full_flag_n, .empty_indicator_n, .almost_full_flag_n, .q_data,
        .rd_valid, .rd_ready, .rd_data
    );
    link_model link_model_i (
        .clock, .wclk_pin, .wen_n, .wr_data, .rclk_pin, .ren_n
    );
    initial begin
        clock = 1'h0;
        forever #2 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic wb(bit we, logic [3:0] a, logic [31:0] d);
        int k;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (k = 0; k < 20 && wb_ack_o !== 1'h1; k++) @(posedge clock);
        r = wb_dat_o;
        if (k == 20) chk("wb_ack_o", 32'h1, 32'h0);
        if (k == 20) wrap_up();
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        @(posedge clock);
    endtask : wb
    task automatic flags();
        chk("full_flag_n", 32'(full_exp), 32'(full_flag_n));
        chk("almost_full", 32'(paf_exp), 32'(almost_full_flag_n));
    endtask : flags
    // k: 0 master, 1 partial, 2 check only
    task automatic rst_pulse(int k);
        if (k == 0) master_reset_n <= 1'h0;
        if (k == 1) partial_reset_n <= 1'h0;
        repeat (4) @(posedge clock);
        master_reset_n <= 1'h1;
        partial_reset_n <= 1'h1;
        repeat (6) @(posedge clock);
        mq.delete();
        sq.delete();
        full_exp = !fw;
        paf_exp = 1'h1;
        flags();
        chk("empty_n", 32'(fw), 32'(empty_indicator_n));
    endtask : rst_pulse
    task automatic put(bit en);
        logic [DATA_W-1:0] d;
        d = DATA_W'($urandom);
        link_model_i.wcyc(en, d);
        if (en && mq.size() < cap) mq.push_back(d);
        full_exp = (mq.size() < cap) ^ fw;
        paf_exp = mq.size() < cap - m;
        flags();
    endtask : put
    task automatic get();
        if (mq.size() > 0) begin
            last = mq.pop_front();
            sq.push_back(last);
        end
        link_model_i.rcyc(1'h1);
        if (!fw) paf_exp = mq.size() < cap - m;
        if (fw && mq.size() > 0) chk("q_data", 32'(mq[0]), 32'(q_data));
        else chk("q_data", 32'(last), 32'(q_data));
        chk("empty_n", 32'((mq.size() > 0) ^ fw), 32'(empty_indicator_n));
        flags();
    endtask : get
    task automatic rd_idle(bit e);
        link_model_i.rcyc(1'h0);
        chk("empty_n", 32'(e), 32'(empty_indicator_n));
    endtask : rd_idle
    // random stalls of the stream consumer
    always @(posedge clock) begin
        rd_ready <= 1'($urandom);
        if (rd_valid === 1'h1 && rd_ready === 1'h1) begin
            if (sq.size() == 0) chk("rd_valid", 32'h0, 32'h1);
            else chk("rd_data", 32'(sq.pop_front()), 32'(rd_data));
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(76));
        sys_rst = 1'h1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 4'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hF;
        master_reset_n = 1'h1;
        partial_reset_n = 1'h1;
        rd_ready = 1'h0;
        last = '0;
        m = 1;
        cap = D;
        repeat (12) @(posedge clock);
        sys_rst <= 1'h0;
        rst_pulse(2);
        wb(0, ADR_CTRL, 0);
        chk("ctrl", 32'(CTRL_RST), r);
        wb(0, ADR_OFFSET, 0);
        chk("offset", 32'(OFFSET_RST) & ((32'h1 << PW) - 32'h1), r);
        wb(0, 4'h2, 0);
        chk("unmapped", 32'h0, r);
        wb(1, ADR_STATUS, 32'hF);
        wb(0, ADR_STATUS, 0);
        chk("status", 32'h5, r);
        wb(1, ADR_OFFSET, 32'(m));
        rst_pulse(0);
        $display("test registers done");
        repeat (D + 1) put(1);
        wb(0, ADR_FILL, 0);
        chk("fill", 32'(D), r);
        rd_idle(0);
        rd_idle(1);
        repeat (D + 1) get();
        put(0);
        repeat (20) @(posedge clock);
        chk("stream_left", 32'h0, 32'(sq.size()));
        $display("test standard done");
        wb(1, ADR_CTRL, 32'h3);
        fw = 1;
        cap = D + 1;
        rst_pulse(0);
        repeat (D + 2) put(1);
        rd_idle(1);
        rd_idle(1);
        rd_idle(0);
        chk("q_data", 32'(mq[0]), 32'(q_data));
        repeat (D + 2) get();
        put(0);
        repeat (20) @(posedge clock);
        chk("stream_left", 32'h0, 32'(sq.size()));
        $display("test fall-through done");
        repeat (2) put(1);
        rst_pulse(1);
        put(1);
        $display("test partial reset done");
        wb(1, ADR_CTRL, 32'hC);
        fw = 0;
        cap = 2 * D;
        rst_pulse(0);
        repeat (2 * D + 1) put(1);
        wb(0, ADR_FILL, 0);
        chk("fill", 32'(2 * D), r);
        $display("test byte width done");
        wrap_up();
    end
endmodule : fifo_status_flag_logic_test

// ---- bench/link_model.sv ----
// far-side writer and reader driving the fifo pins at a 64 ns period
// assumes its tasks are entered just after a rising edge of clock
`timescale 1ns/1ns
module link_model import fifo_flag_pkg::*; (
    // system
    input wire logic clock,
    // write port
    output logic wclk_pin,
    output logic wen_n,
    output logic [DATA_W-1:0] wr_data,
    // read port
    output logic rclk_pin,
    output logic ren_n
);
    initial begin
        wclk_pin = 1'h0;
        rclk_pin = 1'h0;
        wen_n = 1'h1;
        ren_n = 1'h1;
        wr_data = '0;
    end
    ////////////////////////////////////////////////////////////////////
    // one link clock period; the clock stands still between calls
    task automatic wcyc(input bit en, input logic [DATA_W-1:0] d);
        wen_n <= ~en;
        wr_data <= d;
        // seven here plus the return edge keeps the period at 64 ns
        repeat (7) @(posedge clock);
        wclk_pin <= 1'h1;
        repeat (8) @(posedge clock);
        wclk_pin <= 1'h0;
        wen_n <= 1'h1;
        wr_data <= ~d; // released bus must not show the stale word
        @(posedge clock);
    endtask : wcyc
    task automatic rcyc(input bit en);
        ren_n <= ~en;
        repeat (7) @(posedge clock);
        rclk_pin <= 1'h1;
        repeat (8) @(posedge clock);
        rclk_pin <= 1'h0;
        ren_n <= 1'h1;
        @(posedge clock);
    endtask : rcyc
endmodule : link_model

// ---- hw/edge_sync.sv ----
// two flip-flop synchroniser for a pin group, plus rise detect on bit 0
// assumes bit 0 of the group is the foreign clock; the rest is sampled
// with the same delay so data lines up with the detected edge
`timescale 1ns/1ns
module edge_sync #(
    parameter int W = 2
) (
    // system
    input wire logic clock,
    input wire logic sys_rst,
    // pins
    input wire logic [W-1:0] pins_in,
    // synchronised
    output logic [W-1:0] level,
    output logic rise
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] level_ff;
    logic prev_ff;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff <= '0;
            level_ff <= '0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pins_in;
            level_ff <= meta_ff;
            prev_ff <= level_ff[0];
        end
    end

    assign level = level_ff;
    assign rise = level_ff[0] & ~prev_ff;
endmodule : edge_sync

// ---- hw/fifo_flag_core.sv ----
// dual-clock fifo with full/input-ready, empty/output-ready and
// programmable almost-full flags, standard and fall-through modes
// assumes write and read clocks arrive as pins slower than clock/4;
// registers over classic wishbone, words read leave on a stream port
//
// Notes on behaviour
// RULE1: standard mode full pin low while full; high means space remains.
// RULE2: standard mode, no reads: full after exactly D writes.
// RULE3: fall-through mode the pin is input-ready: low with space, high when none.
// RULE4: fall-through mode, no reads: input-ready goes high after D plus one writes.
// RULE5: input-ready counts the word held in the output register.
// RULE6: full/input-ready changes only on write clock edges, two stages. Code: one stage, a read shows at the next write edge.
// RULE7: standard mode empty pin low while no words held, high otherwise.
// RULE8: output-ready falls together with the first word valid on outputs.
// RULE9: output-ready rises only on a read edge with read enable low.
// RULE10: after the last read the outputs keep the old word, reads blocked.
// RULE11: empty/output-ready changes only on read edges, two or three stages.
// RULE12: standard mode almost-full low after depth minus offset writes.
// RULE13: fall-through mode almost-full threshold uses depth plus one.
// RULE14: async timing: almost-full set on write edge, cleared on read edge.
// RULE15: sync timing: almost-full changes only on write clock edges.
// RULE16: timing select is fixed by the outside party during master reset.
// RULE17: counts kept in units of the wider of the two bus widths.
// RULE18: a write while no space is shown is dropped without effect.
// RULE19: master and partial reset return all flags to the empty state.
`timescale 1ns/1ns
module fifo_flag_core import fifo_flag_pkg::*; #(
    parameter int DEPTH = DEPTH_WORDS
) (
    // system
    input wire logic clock,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // write port pins
    input wire logic wclk_pin,
    input wire logic wen_n,
    input wire logic [DATA_W-1:0] wr_data,
    // read port pins
    input wire logic rclk_pin,
    input wire logic ren_n,
    // resets
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    // flags and output register
    output logic full_flag_n,
    output logic empty_indicator_n,
    output logic almost_full_flag_n,
    output logic [DATA_W-1:0] q_data,
    // stream of words read
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [DATA_W-1:0] rd_data
);
    // one spare slot so fall-through can hold depth plus one words
    localparam int MEM_N = 2 * DEPTH + 1;
    localparam int PW = $clog2(MEM_N + 1);
    typedef logic [PW-1:0] ptr_t;

    function automatic ptr_t ptr_inc(ptr_t p);
        return (p == ptr_t'(MEM_N - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    function automatic ptr_t ptr_dist(ptr_t a, ptr_t b);
        return (a >= b) ? a - b : ptr_t'(MEM_N) - b + a;
    endfunction : ptr_dist

    function automatic logic [31:0] sel_merge(logic [31:0] old_v,
                                              logic [31:0] new_v,
                                              logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : sel_merge

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wr_pins_s wr_s;
    rd_pins_s rd_s;
    rst_pins_s rst_s;
    logic wclk_rise;
    logic rclk_rise;
    logic [$bits(wr_pins_s)-1:0] wr_vec;
    logic [$bits(rd_pins_s)-1:0] rd_vec;
    logic [$bits(rst_pins_s)-1:0] rst_vec;

    edge_sync #(.W($bits(wr_pins_s))) u_wsync (
        .clock(clock), .sys_rst(sys_rst),
        .pins_in({wr_data, wen_n, wclk_pin}),
        .level(wr_vec), .rise(wclk_rise));
    edge_sync #(.W($bits(rd_pins_s))) u_rsync (
        .clock(clock), .sys_rst(sys_rst),
        .pins_in({ren_n, rclk_pin}),
        .level(rd_vec), .rise(rclk_rise));
    edge_sync #(.W($bits(rst_pins_s))) u_xsync (
        .clock(clock), .sys_rst(sys_rst),
        .pins_in({master_reset_n, partial_reset_n}),
        .level(rst_vec), .rise());

    assign wr_s = wr_pins_s'(wr_vec);
    assign rd_s = rd_pins_s'(rd_vec);
    assign rst_s = rst_pins_s'(rst_vec);

    logic clear;
    assign clear = ~rst_s.master_n | ~rst_s.partial_n;

    ////////////////////////////////////////////////////////////////////
    // registers and configuration
    logic [3:0] ctrl_ff;
    ptr_t offset_ff;
    flag_cfg_s cfg_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic wb_hit;
    assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_ff;

    // mode bits from ctrl_ff only count while master reset is held
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ff <= flag_cfg_s'(CTRL_RST);
        end else if (!rst_s.master_n) begin
            cfg_ff <= flag_cfg_s'(ctrl_ff); // RULE16
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= CTRL_RST;
            offset_ff <= ptr_t'(OFFSET_RST);
        end else if (wb_hit && wb_we_i) begin
            if (wb_adr_i == ADR_CTRL) begin
                ctrl_ff <= 4'(sel_merge(32'(ctrl_ff), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == ADR_OFFSET) begin
                offset_ff <= ptr_t'(sel_merge(32'(offset_ff), wb_dat_i,
                                              wb_sel_i));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // capacity and storage
    logic byte_mode;
    ptr_t cap;
    ptr_t limit;
    ptr_t thr;
    assign byte_mode = cfg_ff.iw & cfg_ff.ow;
    assign cap = byte_mode ? ptr_t'(2 * DEPTH) : ptr_t'(DEPTH); // RULE17
    assign limit = cap + ptr_t'(cfg_ff.first_word_fall_through_mode); // RULE5
    assign thr = (offset_ff >= limit) ? '0 : limit - offset_ff; // RULE13

    logic [DATA_W-1:0] mem [MEM_N];
    ptr_t wr_ptr_ff, rd_ptr_ff, wp_s1_ff, wp_s2_ff;
    logic ov_ff;
    logic full_ff;
    logic buf_ready;

    ////////////////////////////////////////////////////////////////////
    // next-state terms
    logic wr_take, rd_take, consume, load, nxt_ov;
    ptr_t vis, avail, nxt_wr_ptr, nxt_rd_ptr, nxt_fill;

    assign wr_take = wclk_rise & ~wr_s.wen_n & ~full_ff; // RULE18
    assign vis = cfg_ff.first_word_fall_through_mode ? wp_s2_ff : wp_s1_ff; // RULE11
    assign avail = ptr_dist(vis, rd_ptr_ff);
    assign rd_take = ~cfg_ff.first_word_fall_through_mode & rclk_rise & ~rd_s.ren_n & buf_ready
                   & empty_indicator_n & (avail != '0); // RULE7
    assign consume = cfg_ff.first_word_fall_through_mode & rclk_rise & ~rd_s.ren_n & ov_ff
                   & buf_ready; // RULE10
    assign load = cfg_ff.first_word_fall_through_mode & rclk_rise & (avail != '0)
                & (~ov_ff | consume);
    assign nxt_ov = load | (ov_ff & ~consume);
    assign nxt_wr_ptr = wr_take ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
    assign nxt_rd_ptr = (rd_take | load) ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
    assign nxt_fill = ptr_dist(nxt_wr_ptr, nxt_rd_ptr) + ptr_t'(nxt_ov);

    ////////////////////////////////////////////////////////////////////
    // write side
    always_ff @(posedge clock) begin
        if (wr_take) begin
            mem[wr_ptr_ff] <= wr_s.data;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_ff <= '0;
        end else if (clear) begin
            wr_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
        end
    end

    // write pointer and flag register load on the same write edge, one stage
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            full_ff <= 1'b0;
            full_flag_n <= 1'b1;
        end else if (clear) begin
            full_ff <= 1'b0; // RULE19
            full_flag_n <= ~cfg_ff.first_word_fall_through_mode;
        end else if (wclk_rise) begin // RULE6
            full_ff <= (nxt_fill >= limit); // RULE2 RULE4
            // same level, opposite sense in the two modes
            full_flag_n <= cfg_ff.first_word_fall_through_mode ? (nxt_fill >= limit) // RULE3
                                       : (nxt_fill < limit); // RULE1
        end
    end

    logic almost;
    assign almost = nxt_fill >= thr; // RULE12
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            almost_full_flag_n <= 1'b1;
        end else if (clear) begin
            almost_full_flag_n <= 1'b1; // RULE19
        end else if (cfg_ff.tsel) begin
            if (wclk_rise) begin
                almost_full_flag_n <= ~almost; // RULE15
            end
        end else if (wclk_rise && almost) begin
            almost_full_flag_n <= 1'b0; // RULE14
        end else if (rclk_rise && !almost) begin
            almost_full_flag_n <= 1'b1; // RULE14
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read side
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wp_s1_ff <= '0;
            wp_s2_ff <= '0;
            rd_ptr_ff <= '0;
            ov_ff <= 1'b0;
        end else if (clear) begin
            wp_s1_ff <= '0;
            wp_s2_ff <= '0;
            rd_ptr_ff <= '0;
            ov_ff <= 1'b0;
        end else begin
            if (rclk_rise) begin
                wp_s1_ff <= wr_ptr_ff;
                wp_s2_ff <= wp_s1_ff;
            end
            rd_ptr_ff <= nxt_rd_ptr;
            ov_ff <= nxt_ov & cfg_ff.first_word_fall_through_mode;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q_data <= '0;
        end else if (rd_take || load) begin
            q_data <= mem[rd_ptr_ff]; // RULE8
        end
    end

    // stale write pointer gives standard two stages, fall-through three
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            empty_indicator_n <= 1'b0;
        end else if (clear) begin
            empty_indicator_n <= cfg_ff.first_word_fall_through_mode; // RULE19
        end else if (rclk_rise) begin // RULE11
            if (cfg_ff.first_word_fall_through_mode) begin
                empty_indicator_n <= ~nxt_ov; // RULE8 RULE9
            end else begin
                empty_indicator_n <= ptr_dist(wp_s1_ff, nxt_rd_ptr) != '0;
            end
        end
    end

    pair_buffer #(.W(DATA_W)) u_buf (
        .clock(clock), .sys_rst(sys_rst), .flush(clear),
        .in_valid(rd_take | consume), .in_ready(buf_ready),
        .in_data(cfg_ff.first_word_fall_through_mode ? q_data : mem[rd_ptr_ff]),
        .out_valid(rd_valid), .out_ready(rd_ready), .out_data(rd_data));

    ////////////////////////////////////////////////////////////////////
    // wishbone answer, one wait state
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end else begin
            ack_ff <= wb_hit;
            if (wb_hit) begin
                if (wb_adr_i == ADR_CTRL) begin
                    dat_ff <= 32'(ctrl_ff);
                end else if (wb_adr_i == ADR_OFFSET) begin
                    dat_ff <= 32'(offset_ff);
                end else if (wb_adr_i == ADR_STATUS) begin
                    dat_ff <= '0;
                    dat_ff[STAT_FULL_BIT] <= full_flag_n;
                    dat_ff[STAT_EMPTY_BIT] <= empty_indicator_n;
                    dat_ff[STAT_PAF_BIT] <= almost_full_flag_n;
                    dat_ff[STAT_OV_BIT] <= ov_ff;
                end else if (wb_adr_i == ADR_FILL) begin
                    dat_ff <= 32'(ptr_dist(wr_ptr_ff, rd_ptr_ff)
                                  + ptr_t'(ov_ff));
                end else begin
                    dat_ff <= '0;
                end
            end
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_full_std;
        @(posedge clock) disable iff (sys_rst)
        (wclk_rise && !clear && !cfg_ff.first_word_fall_through_mode && nxt_fill == cap)
            |=> !full_flag_n;
    endproperty
    a_full_std: assert property (p_full_std) // RULE1
        else $error("full flag not low at capacity");

    property p_full_d_minus1;
        @(posedge clock) disable iff (sys_rst)
        (wclk_rise && !clear && !cfg_ff.first_word_fall_through_mode && nxt_fill + 1'b1 == cap)
            |=> full_flag_n;
    endproperty
    a_full_d_minus1: assert property (p_full_d_minus1) // RULE2
        else $error("full flag low one word early");

    property p_ir_first_word_fall_through_mode;
        @(posedge clock) disable iff (sys_rst)
        (wclk_rise && !clear && cfg_ff.first_word_fall_through_mode)
            |=> full_flag_n == ($past(nxt_fill) == cap + 1'b1);
    endproperty
    a_ir_first_word_fall_through_mode: assert property (p_ir_first_word_fall_through_mode) // RULE4
        else $error("input ready wrong at depth plus one");

    property p_drop;
        @(posedge clock) disable iff (sys_rst)
        (wclk_rise && full_ff && !clear) |=> $stable(wr_ptr_ff);
    endproperty
    a_drop: assert property (p_drop) // RULE18
        else $error("write accepted while full");

    property p_full_edge;
        @(posedge clock) disable iff (sys_rst)
        !$stable(full_flag_n) |-> $past(wclk_rise || clear);
    endproperty
    a_full_edge: assert property (p_full_edge) // RULE6
        else $error("full flag moved off a write edge");

    property p_empty_edge;
        @(posedge clock) disable iff (sys_rst)
        !$stable(empty_indicator_n) |-> $past(rclk_rise || clear);
    endproperty
    a_empty_edge: assert property (p_empty_edge) // RULE11
        else $error("empty flag moved off a read edge");

    property p_or_rise;
        @(posedge clock) disable iff (sys_rst)
        (cfg_ff.first_word_fall_through_mode && $rose(empty_indicator_n) && !$past(clear))
            |-> $past(rclk_rise && !rd_s.ren_n);
    endproperty
    a_or_rise: assert property (p_or_rise) // RULE9
        else $error("output ready rose without a true read");

    property p_or_with_data;
        @(posedge clock) disable iff (sys_rst)
        (cfg_ff.first_word_fall_through_mode && $rose(ov_ff)) |-> $fell(empty_indicator_n)
            && !$stable(rd_ptr_ff);
    endproperty
    a_or_with_data: assert property (p_or_with_data) // RULE8
        else $error("output ready not aligned with first word");

    property p_hold_last;
        @(posedge clock) disable iff (sys_rst)
        (cfg_ff.first_word_fall_through_mode && empty_indicator_n && !load) |=> $stable(q_data);
    endproperty
    a_hold_last: assert property (p_hold_last) // RULE10
        else $error("outputs changed while no word ready");

    property p_paf_sync;
        @(posedge clock) disable iff (sys_rst)
        (cfg_ff.tsel && !$stable(almost_full_flag_n))
            |-> $past(wclk_rise || clear);
    endproperty
    a_paf_sync: assert property (p_paf_sync) // RULE15
        else $error("sync almost-full moved off a write edge");

    property p_paf_async;
        @(posedge clock) disable iff (sys_rst)
        (!cfg_ff.tsel && $rose(almost_full_flag_n))
            |-> $past(rclk_rise || clear);
    endproperty
    a_paf_async: assert property (p_paf_async) // RULE14
        else $error("async almost-full cleared off a read edge");

    property p_paf_level;
        @(posedge clock) disable iff (sys_rst)
        (wclk_rise && !clear && nxt_fill >= thr) |=> !almost_full_flag_n;
    endproperty
    a_paf_level: assert property (p_paf_level) // RULE12
        else $error("almost-full not low at threshold");

    property p_clear;
        @(posedge clock) disable iff (sys_rst)
        clear |=> almost_full_flag_n && !ov_ff
            && (full_flag_n == !$past(cfg_ff.first_word_fall_through_mode));
    endproperty
    a_clear: assert property (p_clear) // RULE19
        else $error("flags not empty after reset");
endmodule : fifo_flag_core

// ---- hw/pair_buffer.sv ----
// two-entry skid buffer with valid/ready on both sides
// assumes the source pushes only while in_ready is high
`timescale 1ns/1ns
module pair_buffer #(
    parameter int W = 18
) (
    // system
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] head_ff;
    logic [W-1:0] tail_ff;
    logic hv_ff;
    logic tv_ff;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            head_ff <= '0;
            tail_ff <= '0;
            hv_ff <= 1'b0;
            tv_ff <= 1'b0;
        end else if (flush) begin
            hv_ff <= 1'b0;
            tv_ff <= 1'b0;
        end else if (out_ready || !hv_ff) begin
            if (tv_ff) begin
                head_ff <= tail_ff;
                hv_ff <= 1'b1;
                tv_ff <= 1'b0;
            end else begin
                hv_ff <= in_valid;
                if (in_valid) begin
                    head_ff <= in_data;
                end
            end
        end else if (in_valid && !tv_ff) begin
            // head stalled: park the word so nothing is lost
            tail_ff <= in_data;
            tv_ff <= 1'b1;
        end
    end

    assign in_ready = ~tv_ff;
    assign out_valid = hv_ff;
    assign out_data = head_ff;
endmodule : pair_buffer

// ---- include/fifo_flag_pkg.sv ----
// shared constants and carriers for the fifo status flag block
// assumes a 32-bit classic wishbone slave and pin groups synchronised
// into the single system clock
package fifo_flag_pkg;
    // register byte offsets
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_OFFSET = 4'h4;
    localparam logic [3:0] ADR_STATUS = 4'h8;
    localparam logic [3:0] ADR_FILL = 4'hC;
    // control field positions
    localparam int CTRL_FIRST_WORD_FALL_THROUGH_MODE_BIT = 0;
    localparam int CTRL_TSEL_BIT = 1;
    localparam int CTRL_IW_BIT = 2;
    localparam int CTRL_OW_BIT = 3;
    // status field positions
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_EMPTY_BIT = 1;
    localparam int STAT_PAF_BIT = 2;
    localparam int STAT_OV_BIT = 3;
    // reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [17:0] OFFSET_RST = 18'h0003F;
    // geometry: words of the smallest variant at word width
    localparam int DEPTH_WORDS = 512;
    localparam int DATA_W = 18;

    typedef struct packed {
        logic ow;
        logic iw;
        logic tsel;
        logic first_word_fall_through_mode;
    } flag_cfg_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic wen_n;
        logic clk;
    } wr_pins_s;

    typedef struct packed {
        logic ren_n;
        logic clk;
    } rd_pins_s;

    typedef struct packed {
        logic master_n;
        logic partial_n;
    } rst_pins_s;
endpackage : fifo_flag_pkg
